// File: brt_consts.svh
// Register offsets, field positions, reset values and sizes of the block RAM tile
`ifndef BRT_CONSTS_SVH
`define BRT_CONSTS_SVH
// ==========================================================
// Array and port sizes
`define TILE_BITS 18432
`define TILE_DW 36
`define TILE_AW 14
// ==========================================================
// Register byte offsets (low address byte)
`define OFF_CTRL 8'h00
`define OFF_PORTA_CFG 8'h04
`define OFF_PORTB_CFG 8'h08
`define OFF_STATUS 8'h0C
`define OFF_INIT_ADDR 8'h10
`define OFF_INIT_DATA 8'h14
// ==========================================================
// Field positions
`define CTRL_MODE_LSB 0
`define CTRL_PAR_EN 2
`define CTRL_SYNC_RST 3
`define CTRL_LOAD 4
`define PCFG_WID_LSB 0
`define PCFG_WM_LSB 3
`define PCFG_OREG 5
`define ST_CFG_ERR 0
`define ST_PERR_A 1
`define ST_PERR_B 2
// ==========================================================
// Reset values and answers
`define CTRL_RST 5'h00
`define PCFG_RST 6'h05
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: brt_pkg.sv
// Types shared by the block RAM tile and its port output stage
package brt_pkg;
  `include "brt_consts.svh"

  typedef enum logic [1:0] {MODE_SINGLE, MODE_TRUE_DUAL, MODE_PSEUDO_DUAL, MODE_BAD} mem_mode_t;
  typedef enum logic [1:0] {WM_NORMAL, WM_WRITE_THROUGH, WM_READ_BEFORE_WRITE, WM_BAD} write_mode_t;
  typedef enum logic [2:0] {WID_1, WID_2, WID_4, WID_9, WID_18, WID_36, WID_BAD6, WID_BAD7} width_code_t;

  // Whole state of the tile: array, registers, bus slave, input registers
  typedef struct packed {
    logic [`TILE_BITS-1:0] mem;
    logic [4:0] ctrl;
    logic [1:0][5:0] pcfg;
    logic [2:0] status;
    logic [10:0] init_addr;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] pv;
    logic [1:0] pwe;
    logic [1:0][13:0] paddr;
    logic [1:0][35:0] pwd;
    logic [1:0][3:0] pbe;
  } tile_state_t;

  // State of one port output stage
  typedef struct packed {
    logic [35:0] latch;
    logic [35:0] q;
  } stage_state_t;
endpackage

// File: port_stage_if.sv
// Signals between the tile array and one port output stage
`timescale 1ns/1ps
interface port_stage_if;
  import brt_pkg::*;
  logic ce;
  logic fire;
  logic is_write;
  logic [35:0] wr_word;
  logic [35:0] old_word;
  write_mode_t wmode;
  logic out_reg_en;
  logic sync_rst;
  logic local_rst;
  logic global_rst;
  logic [35:0] rdata;
  modport tile (output ce, fire, is_write, wr_word, old_word, wmode, out_reg_en, sync_rst, local_rst,
                global_rst, input rdata);
  modport stage (input ce, fire, is_write, wr_word, old_word, wmode, out_reg_en, sync_rst, local_rst,
                 global_rst, output rdata);
endinterface

// File: port_output_stage.sv
// Output latch, optional output register and output reset of one tile port
`timescale 1ns/1ps
module port_output_stage
  import brt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  port_stage_if.stage ps
);
  stage_state_t s;
  stage_state_t next_s;
  logic clear;

  // ==========================================================
  // Next state: latch follows the write mode, q is the port output
  always_comb begin
    next_s = s;
    // Synchronous flavour waits for a clock-enabled edge, asynchronous one does not
    clear = (ps.local_rst | ps.global_rst) & (~ps.sync_rst | ps.ce);
    if (ps.fire) begin
      if (!ps.is_write) begin
        next_s.latch = ps.old_word;
      end else begin
        case (ps.wmode)
          WM_WRITE_THROUGH: next_s.latch = ps.wr_word;
          WM_READ_BEFORE_WRITE: next_s.latch = ps.old_word;
          default: next_s.latch = s.latch;
        endcase
      end
    end
    if (ps.out_reg_en) begin
      if (ps.ce) begin
        next_s.q = s.latch;
      end
    end else begin
      next_s.q = next_s.latch;
    end
    if (clear) begin
      next_s = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ps.rdata = s.q;
endmodule

// File: block_ram_tile.sv
// Block RAM tile: shared bit array, two ports, AXI4-Lite configuration slave
//
// Function
// - One 18-Kbit array with input and output registers, per-port clock enable.
// - Single port shapes 16Kx1, 8Kx2, 4Kx4, 2Kx9, 1Kx18, 512x36.
// - True dual port allows widths 1 to 18 only, never 36.
// - Pseudo dual port offers the same shapes as single port.
// - One parity bit per byte is stored and checked on read.
// - At 18 and 36 bits, per-byte write enables select written bytes.
// - Both ports may use different widths on the same storage.
// - Bits laid out LSB to MSB per word, each port using its width.
// - Contents may be preloaded before normal operation.
// - Address and write data are registered at the array input.
// - Read output register is optional, enabled or bypassed by configuration.
// - Normal mode: output changes only on reads, held during writes.
// - Write-through mode: written data appears on the port output.
// - Read-before-write mode: old word appears; widths 9, 18, 36 only.
// - Output latch reset is selectable asynchronous or synchronous; here the asynchronous one acts at the next sys_clk edge, ignoring clock enable.
// - Each port's local reset clears only that port's output.
// - Device-wide active-low reset clears both port outputs.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module block_ram_tile
  import brt_pkg::*;
#(
  parameter int DATA_W = 36,
  parameter int ADDR_W = 14
)(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic device_wide_reset_n,
  input wire logic a_ce,
  input wire logic a_we,
  input wire logic [ADDR_W-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  input wire logic [3:0] a_byte_en,
  input wire logic first_port_output_reset,
  output logic [DATA_W-1:0] a_rdata,
  input wire logic b_ce,
  input wire logic b_we,
  input wire logic [ADDR_W-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata,
  input wire logic [3:0] b_byte_en,
  input wire logic second_port_output_reset,
  output logic [DATA_W-1:0] b_rdata
);
  // The array geometry is fixed; other widths cannot be served
  if (DATA_W != `TILE_DW || ADDR_W != `TILE_AW) begin : g_bad_param
    $error("block_ram_tile supports only 36-bit data and 14-bit addresses");
  end

  // ==========================================================
  // Decoding helpers
  function automatic logic [5:0] width_of(input logic [2:0] code);
    case (width_code_t'(code))
      WID_1: width_of = 6'h01;
      WID_2: width_of = 6'h02;
      WID_4: width_of = 6'h04;
      WID_9: width_of = 6'h09;
      WID_18: width_of = 6'h12;
      WID_36: width_of = 6'h24;
      default: width_of = 6'h00;
    endcase
  endfunction

  // Bit offset of a word; addresses wrap at the shape's depth
  function automatic logic [14:0] offset_of(input logic [2:0] code, input logic [13:0] addr);
    logic [13:0] mask;
    mask = 14'h0000;
    case (width_code_t'(code))
      WID_1: mask = 14'h3FFF;
      WID_2: mask = 14'h1FFF;
      WID_4: mask = 14'h0FFF;
      WID_9: mask = 14'h07FF;
      WID_18: mask = 14'h03FF;
      WID_36: mask = 14'h01FF;
      default: mask = 14'h0000;
    endcase
    offset_of = 15'({1'b0, addr & mask} * 15'(width_of(code)));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    for (int k = 0; k < 4; k++) begin
      merge[8*k +: 8] = strb[k] ? nw[8*k +: 8] : old[8*k +: 8];
    end
  endfunction

  tile_state_t s;
  tile_state_t next_s;
  logic [1:0][35:0] old_word;
  logic cfg_err;
  port_stage_if ps [2] ();

  mem_mode_t mode;
  assign mode = mem_mode_t'(s.ctrl[`CTRL_MODE_LSB +: 2]);

  // ==========================================================
  // Configuration check: shapes and write modes the tile cannot serve
  always_comb begin
    cfg_err = (mode == MODE_BAD);
    for (int p = 0; p < 2; p++) begin
      if (width_of(s.pcfg[p][`PCFG_WID_LSB +: 3]) == 6'h00) cfg_err = 1'b1;
      if (write_mode_t'(s.pcfg[p][`PCFG_WM_LSB +: 2]) == WM_BAD) cfg_err = 1'b1;
      if (write_mode_t'(s.pcfg[p][`PCFG_WM_LSB +: 2]) == WM_READ_BEFORE_WRITE &&
          width_of(s.pcfg[p][`PCFG_WID_LSB +: 3]) < 6'h09) cfg_err = 1'b1;
      if (mode == MODE_TRUE_DUAL && width_code_t'(s.pcfg[p][`PCFG_WID_LSB +: 3]) == WID_36) begin
        cfg_err = 1'b1;
      end
    end
  end

  // ==========================================================
  // Array read port: old word at each captured address, before this cycle's write
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      old_word[p] = '0;
      for (int i = 0; i < 36; i++) begin
        if (i < int'(width_of(s.pcfg[p][2:0])) && int'(offset_of(s.pcfg[p][2:0], s.paddr[p])) + i < `TILE_BITS) begin
          old_word[p][i] = s.mem[int'(offset_of(s.pcfg[p][2:0], s.paddr[p])) + i];
        end
      end
    end
  end

  // ==========================================================
  // Next state: bus slave, registers, input capture, array writes
  always_comb begin
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic cap;
    logic [14:0] off;
    logic [5:0] w;
    next_s = s;
    wa = s.aw_got ? s.awaddr_q : awaddr[7:0];
    wd = s.w_got ? s.wdata_q : wdata;
    ws = s.w_got ? s.wstrb_q : wstrb;
    cap = ~s.ctrl[`CTRL_LOAD] & ~cfg_err;
    off = '0;
    w = '0;
    next_s.status[`ST_CFG_ERR] = cfg_err;
    // Write address and data are taken independently, response follows both
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr_q = awaddr[7:0];
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata_q = wdata;
      next_s.wstrb_q = wstrb;
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    if (next_s.aw_got && next_s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `RESP_OKAY;
      case (wa)
        `OFF_CTRL: next_s.ctrl = 5'(merge({27'h0, s.ctrl}, wd, ws));
        `OFF_PORTA_CFG: next_s.pcfg[0] = 6'(merge({26'h0, s.pcfg[0]}, wd, ws));
        `OFF_PORTB_CFG: next_s.pcfg[1] = 6'(merge({26'h0, s.pcfg[1]}, wd, ws));
        `OFF_STATUS: next_s.status[2:1] = s.status[2:1] & ~(wd[2:1] & {2{ws[0]}});
        `OFF_INIT_ADDR: next_s.init_addr = 11'(merge({21'h0, s.init_addr}, wd, ws));
        `OFF_INIT_DATA: begin
          // Preload only while the tile is held in its load phase
          if (s.ctrl[`CTRL_LOAD]) begin
            next_s.mem[int'(s.init_addr) * 9 +: 9] = wd[8:0];
            next_s.init_addr = s.init_addr + 11'h001;
          end
        end
        default: next_s.bresp = `RESP_SLVERR;
      endcase
    end
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready = ~next_s.w_got & ~next_s.bvalid;
    // Read channel: one read in flight, answer one cycle after it is taken
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = `RESP_OKAY;
      case (araddr[7:0])
        `OFF_CTRL: next_s.rdata = {27'h0, s.ctrl};
        `OFF_PORTA_CFG: next_s.rdata = {26'h0, s.pcfg[0]};
        `OFF_PORTB_CFG: next_s.rdata = {26'h0, s.pcfg[1]};
        `OFF_STATUS: next_s.rdata = {29'h0, s.status};
        `OFF_INIT_ADDR: next_s.rdata = {21'h0, s.init_addr};
        `OFF_INIT_DATA: next_s.rdata = 32'h0000_0000;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `RESP_SLVERR;
        end
      endcase
    end
    // Input registers: pseudo dual port makes A write-only and B read-only
    next_s.pv[0] = a_ce & cap & (mode != MODE_PSEUDO_DUAL | a_we);
    next_s.pv[1] = b_ce & cap & (mode != MODE_SINGLE);
    next_s.pwe[0] = a_we;
    next_s.pwe[1] = b_we & (mode == MODE_TRUE_DUAL);
    if (a_ce) begin
      next_s.paddr[0] = a_addr;
      next_s.pwd[0] = a_wdata;
      next_s.pbe[0] = a_byte_en;
    end
    if (b_ce) begin
      next_s.paddr[1] = b_addr;
      next_s.pwd[1] = b_wdata;
      next_s.pbe[1] = b_byte_en;
    end
    // Array stage; B is applied after A, so B wins a same-bit collision
    for (int p = 0; p < 2; p++) begin
      off = offset_of(s.pcfg[p][2:0], s.paddr[p]);
      w = width_of(s.pcfg[p][2:0]);
      if (s.pv[p] && s.pwe[p]) begin
        for (int i = 0; i < 36; i++) begin
          if (i < int'(w) && (w < 6'h12 || s.pbe[p][i / 9]) && int'(off) + i < `TILE_BITS) begin
            next_s.mem[int'(off) + i] = s.pwd[p][i];
          end
        end
      end
      // Even parity per 9-bit group; a new error wins over a clear
      if (s.pv[p] && !s.pwe[p] && s.ctrl[`CTRL_PAR_EN]) begin
        for (int k = 0; k < 4; k++) begin
          if (k * 9 + 9 <= int'(w) && old_word[p][k * 9 + 8] != ^old_word[p][k * 9 +: 8]) begin
            next_s.status[`ST_PERR_A + p] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= `CTRL_RST;
      s.pcfg <= {`PCFG_RST, `PCFG_RST};
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Port output stages, one per port
  for (genvar g = 0; g < 2; g++) begin : g_port
    assign ps[g].ce = (g == 0) ? a_ce : b_ce;
    assign ps[g].fire = s.pv[g];
    assign ps[g].is_write = s.pwe[g];
    assign ps[g].wr_word = s.pwd[g];
    assign ps[g].old_word = old_word[g];
    assign ps[g].wmode = write_mode_t'(s.pcfg[g][`PCFG_WM_LSB +: 2]);
    assign ps[g].out_reg_en = s.pcfg[g][`PCFG_OREG];
    assign ps[g].sync_rst = s.ctrl[`CTRL_SYNC_RST];
    assign ps[g].local_rst = (g == 0) ? first_port_output_reset : second_port_output_reset;
    assign ps[g].global_rst = ~device_wide_reset_n;
    port_output_stage u_stage (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .ps(ps[g].stage)
    );
  end

  assign a_rdata = ps[0].rdata;
  assign b_rdata = ps[1].rdata;
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rresp = s.rresp;
  assign rdata = s.rdata;

  // ==========================================================
  // Assertions on port A timing, write modes, resets and the 36-bit true dual port check
  logic quiet_a;
  assign quiet_a = ~first_port_output_reset & device_wide_reset_n;

  property p_capture;
    @(posedge sys_clk) disable iff (!rst_n) a_ce |=> s.paddr[0] == $past(a_addr) && s.pwd[0] == $past(a_wdata);
  endproperty
  a_capture: assert property (p_capture) else $error("port A input not captured");

  property p_read_bypass;
    @(posedge sys_clk) disable iff (!rst_n)
      s.pv[0] && !s.pwe[0] && !s.pcfg[0][`PCFG_OREG] && quiet_a |=> a_rdata == $past(old_word[0]);
  endproperty
  a_read_bypass: assert property (p_read_bypass) else $error("bypassed read data wrong");

  property p_read_oreg;
    @(posedge sys_clk) disable iff (!rst_n)
      (s.pv[0] && !s.pwe[0] && s.pcfg[0][`PCFG_OREG] && quiet_a) ##1 (a_ce && quiet_a && !s.pv[0])
      |=> a_rdata == $past(old_word[0], 2);
  endproperty
  a_read_oreg: assert property (p_read_oreg) else $error("registered read data wrong");

  property p_normal_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      s.pv[0] && s.pwe[0] && ps[0].wmode == WM_NORMAL && !s.pcfg[0][`PCFG_OREG] && quiet_a |=> $stable(a_rdata);
  endproperty
  a_normal_hold: assert property (p_normal_hold) else $error("normal write changed output");

  property p_write_through;
    @(posedge sys_clk) disable iff (!rst_n)
      s.pv[0] && s.pwe[0] && ps[0].wmode == WM_WRITE_THROUGH && !s.pcfg[0][`PCFG_OREG] && quiet_a
      |=> a_rdata == $past(s.pwd[0]);
  endproperty
  a_write_through: assert property (p_write_through) else $error("write data not shown");

  property p_rbw;
    @(posedge sys_clk) disable iff (!rst_n)
      s.pv[0] && s.pwe[0] && ps[0].wmode == WM_READ_BEFORE_WRITE && !s.pcfg[0][`PCFG_OREG] && quiet_a
      |=> a_rdata == $past(old_word[0]);
  endproperty
  a_rbw: assert property (p_rbw) else $error("old word not shown on write");

  property p_local_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      first_port_output_reset && !s.ctrl[`CTRL_SYNC_RST] && !second_port_output_reset && device_wide_reset_n
      && !s.pv[1] && !s.pcfg[1][`PCFG_OREG] |=> a_rdata == '0 && $stable(b_rdata);
  endproperty
  a_local_reset: assert property (p_local_reset) else $error("local reset wrong");

  property p_global_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      !device_wide_reset_n && !s.ctrl[`CTRL_SYNC_RST] |=> a_rdata == '0 && b_rdata == '0;
  endproperty
  a_global_reset: assert property (p_global_reset) else $error("global reset missed a port");

  property p_sync_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      first_port_output_reset && s.ctrl[`CTRL_SYNC_RST] && !a_ce && !s.pv[0] && device_wide_reset_n
      |=> $stable(a_rdata);
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync reset acted without enable");

  property p_no_36_dual;
    @(posedge sys_clk) disable iff (!rst_n)
      mode == MODE_TRUE_DUAL && width_code_t'(s.pcfg[0][2:0]) == WID_36 |=> s.status[`ST_CFG_ERR] && !s.pv[0];
  endproperty
  a_no_36_dual: assert property (p_no_36_dual) else $error("36-bit dual port accepted");

  c_write_through: cover property (@(posedge sys_clk) s.pv[0] && s.pwe[0] && ps[0].wmode == WM_WRITE_THROUGH);
  c_rbw: cover property (@(posedge sys_clk) s.pv[0] && s.pwe[0] && ps[0].wmode == WM_READ_BEFORE_WRITE);
  c_dual_read: cover property (@(posedge sys_clk) s.pv[0] && s.pv[1] && mode == MODE_TRUE_DUAL);
endmodule

// File: fabric_user.sv
// Fabric user logic model that drives both tile ports and their resets
`timescale 1ns/1ps
module fabric_user (
  input wire logic sys_clk,
  output logic a_ce,
  output logic a_we,
  output logic [13:0] a_addr,
  output logic [35:0] a_wdata,
  output logic [3:0] a_byte_en,
  output logic b_ce,
  output logic b_we,
  output logic [13:0] b_addr,
  output logic [35:0] b_wdata,
  output logic [3:0] b_byte_en,
  output logic first_port_output_reset,
  output logic second_port_output_reset,
  output logic device_wide_reset_n
);
  // ==========================================================
  // Idle state: no access, no reset
  initial begin
    {a_ce, a_we, a_addr, a_wdata, a_byte_en} = '0;
    {b_ce, b_we, b_addr, b_wdata, b_byte_en} = '0;
    {first_port_output_reset, second_port_output_reset} = 2'h0;
    device_wide_reset_n = 1'b1;
  end

  // ==========================================================
  // One access on port p (0 = A, 1 = B), returns at the capture edge
  task automatic op(input logic p, input logic we, input logic [13:0] ad, input logic [35:0] d,
                    input logic [3:0] be);
    @(posedge sys_clk);
    if (!p) begin
      {a_ce, a_we, a_addr, a_wdata, a_byte_en} <= {1'b1, we, ad, d, be};
    end else begin
      {b_ce, b_we, b_addr, b_wdata, b_byte_en} <= {1'b1, we, ad, d, be};
    end
    @(posedge sys_clk);
    // Released lines show inverted values so a stale bus can never match
    {a_ce, a_we, b_ce, b_we} <= 4'h0;
    {a_addr, b_addr, a_wdata, b_wdata} <= {~ad, ~ad, ~d, ~d};
  endtask

  // ==========================================================
  // One-cycle pulse: 0 port A reset, 1 port B reset, 2 device-wide reset
  task automatic pulse(input int k);
    @(posedge sys_clk);
    if (k == 0) first_port_output_reset <= 1'b1;
    if (k == 1) second_port_output_reset <= 1'b1;
    if (k == 2) device_wide_reset_n <= 1'b0;
    @(posedge sys_clk);
    {first_port_output_reset, second_port_output_reset, device_wide_reset_n} <= 3'h1;
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench of the block RAM tile with the fabric user model
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic a_ce, a_we, b_ce, b_we, first_port_output_reset, second_port_output_reset, device_wide_reset_n;
  logic [13:0] a_addr, b_addr;
  logic [35:0] a_wdata, b_wdata, a_rdata, b_rdata;
  logic [3:0] a_byte_en, b_byte_en;
  int err_count = 0;
  int n_checks = 0;
  localparam logic [35:0] d1 = 36'h9ABCD1234, d2 = 36'h5A5A0F0F1, d3 = 36'h123456789;
  localparam logic [35:0] lo = {18'h0, d1[17:0]}, hi = {18'h0, d1[35:18]};

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  block_ram_tile block_ram_tile_i (.sys_clk, .rst_n, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .device_wide_reset_n, .a_ce, .a_we, .a_addr, .a_wdata, .a_byte_en,
    .first_port_output_reset, .a_rdata, .b_ce, .b_we, .b_addr, .b_wdata, .b_byte_en,
    .second_port_output_reset, .b_rdata);
  fabric_user fabric_user_i (.sys_clk, .a_ce, .a_we, .a_addr, .a_wdata, .a_byte_en, .b_ce, .b_we, .b_addr,
    .b_wdata, .b_byte_en, .first_port_output_reset, .second_port_output_reset, .device_wide_reset_n);

  // ==========================================================
  // Verdict and comparisons
  task automatic tally_and_finish;
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic give_up;
    err_count++;
    $display("BAD %0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t register got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t response got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_port(input logic [35:0] got, input logic [35:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t port data got %h want %h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // AXI4-Lite master: each channel held until its own handshake edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {24'h0, a, d, 3'h7};
    do begin
      @(posedge sys_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    resp = bresp;
    bready <= 1'b0;
    if (n >= 50) give_up();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {24'h0, a, 2'h3};
    do begin
      @(posedge sys_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n >= 50) give_up();
  endtask
  // Port access, then look at the output once the array edge has landed
  task automatic port_chk(input logic p, input logic we, input logic [13:0] ad, input logic [35:0] d,
                          input logic [3:0] be, input logic [35:0] exp);
    fabric_user_i.op(p, we, ad, d, be);
    @(posedge sys_clk);
    #1;
    chk_port(p ? b_rdata : a_rdata, exp);
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_regs;
    axi_rd(8'h04);
    chk_reg(rd, 32'h00000005);
    axi_rd(8'h18);
    chk_resp(resp, 2'h2);
    chk_reg(rd, 32'h0);
    axi_wr(8'h18, 32'hFFFFFFFF);
    chk_resp(resp, 2'h2);
    axi_rd(8'h00);
    chk_reg(rd, 32'h0);
  endtask
  task automatic s_single;
    port_chk(1'b0, 1'b1, 14'h5, d1, 4'hF, 36'h0);
    port_chk(1'b0, 1'b0, 14'h5, d3, 4'h0, d1);
    port_chk(1'b0, 1'b1, 14'h5, 36'h0, 4'h1, d1);
    port_chk(1'b0, 1'b0, 14'h5, d3, 4'h0, d1 & ~36'h1FF);
  endtask
  task automatic s_preload;
    axi_wr(8'h00, 32'h10);
    axi_wr(8'h10, 32'h0);
    axi_wr(8'h14, 32'h1A5);
    axi_wr(8'h00, 32'h0);
    port_chk(1'b0, 1'b0, 14'h0, d3, 4'h0, 36'h1A5);
  endtask
  task automatic s_wmodes;
    axi_wr(8'h04, 32'h0D);
    port_chk(1'b0, 1'b1, 14'h6, d2, 4'hF, d2);
    axi_wr(8'h04, 32'h15);
    port_chk(1'b0, 1'b1, 14'h6, d3, 4'hF, d2);
    axi_wr(8'h04, 32'h12);
    axi_rd(8'h0C);
    chk_reg(rd, 32'h1);
  endtask
  task automatic s_mixed;
    axi_wr(8'h04, 32'h05);
    axi_wr(8'h08, 32'h04);
    axi_wr(8'h00, 32'h02);
    fabric_user_i.op(1'b0, 1'b1, 14'h1, d1, 4'hF);
    port_chk(1'b1, 1'b0, 14'h2, d3, 4'h0, lo);
    port_chk(1'b1, 1'b0, 14'h3, d3, 4'h0, hi);
    axi_wr(8'h00, 32'h01);
    axi_rd(8'h0C);
    chk_reg(rd, 32'h1);
    axi_wr(8'h04, 32'h04);
    axi_rd(8'h0C);
    chk_reg(rd, 32'h0);
  endtask
  task automatic s_resets;
    port_chk(1'b0, 1'b0, 14'h3, d3, 4'h0, hi);
    port_chk(1'b1, 1'b0, 14'h2, d3, 4'h0, lo);
    fabric_user_i.pulse(0);
    #1;
    chk_port(a_rdata, 36'h0);
    chk_port(b_rdata, lo);
    fabric_user_i.pulse(2);
    #1;
    chk_port(b_rdata, 36'h0);
    axi_wr(8'h00, 32'h09);
    port_chk(1'b0, 1'b0, 14'h3, d3, 4'h0, hi);
    fabric_user_i.pulse(0);
    #1;
    chk_port(a_rdata, hi);
  endtask
  task automatic s_outreg;
    axi_wr(8'h00, 32'h01);
    axi_wr(8'h04, 32'h24);
    fabric_user_i.pulse(0);
    port_chk(1'b0, 1'b0, 14'h3, d3, 4'h0, 36'h0);
    port_chk(1'b0, 1'b0, 14'h3, d3, 4'h0, hi);
  endtask
  // Bad parity stored, read back twice through the output register, then W1C of the sticky flag
  task automatic s_parity;
    axi_wr(8'h00, 32'h05);
    fabric_user_i.op(1'b0, 1'b1, 14'h7, 36'h1, 4'hF);
    fabric_user_i.op(1'b0, 1'b0, 14'h7, d3, 4'h0);
    fabric_user_i.op(1'b0, 1'b0, 14'h7, d3, 4'h0);
    #1;
    chk_port(a_rdata, 36'h1);
    axi_rd(8'h0C);
    chk_reg(rd, 32'h2);
    axi_wr(8'h0C, 32'h2);
    axi_rd(8'h0C);
    chk_reg(rd, 32'h0);
  endtask

  // ==========================================================
  // Main sequence: reset for six cycles, then every scenario once
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    s_regs();
    s_single();
    s_preload();
    s_wmodes();
    s_mixed();
    s_resets();
    s_outreg();
    s_parity();
    tally_and_finish();
  end
endmodule
